// File: lpac_map.svh
/*
  Constants for the display drive power and area controller.
  Assumes inclusion by the package only; the controller uses its macros.
*/
`ifndef LPAC_MAP_SVH
`define LPAC_MAP_SVH

// -----------------------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------------------
`define LPAC_OFF_CMD     4'h0
`define LPAC_OFF_CFG     4'h1
`define LPAC_OFF_STATUS  4'h2
`define LPAC_OFF_SEG     4'h3
`define LPAC_OFF_CONTR   4'h4

// -----------------------------------------------------------------------------
// Command word fields (CMD write)
// -----------------------------------------------------------------------------
`define LPAC_CMD_OP_LSB  0
`define LPAC_CMD_ARG_LSB 4
`define LPAC_CMD_AREA_LSB 8
`define LPAC_OP_DISP_ON     4'h1
`define LPAC_OP_OFF_BLANK   4'h2
`define LPAC_OP_OFF_HALT    4'h3
`define LPAC_OP_CIRC_EN     4'h4
`define LPAC_OP_CIRC_DIS    4'h5
`define LPAC_OP_CONTROL     4'h6
`define LPAC_FLAG_DRV       4'h1
`define LPAC_FLAG_AREA      4'h2
`define LPAC_SEL_B2C        4'h1
`define LPAC_SEL_C2B        4'h2
`define LPAC_AREA_A         4'h1
`define LPAC_AREA_B         4'h2
`define LPAC_AREA_BLINK     4'h3

// -----------------------------------------------------------------------------
// Config bits and generator codes
// -----------------------------------------------------------------------------
`define LPAC_CFG_SELF_WAIT  0
`define LPAC_CFG_GEN_LSB    1
`define LPAC_GEN_RES        2'h0
`define LPAC_GEN_BOOST      2'h1
`define LPAC_GEN_CAP        2'h2
`define LPAC_CFG_RESET      3'h1

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define LPAC_CLK_MHZ        100
`define LPAC_VREF_SETUP_US  5
`define LPAC_BOOST_WAIT_MS  500
`define LPAC_VREF_CYC       (`LPAC_VREF_SETUP_US * `LPAC_CLK_MHZ)
`define LPAC_BOOST_CYC      (`LPAC_BOOST_WAIT_MS * 1000 * `LPAC_CLK_MHZ)

`endif

// File: lpac_pkg.sv
/*
  Types for the display drive power and area controller.
  Assumes lpac_map.svh is on the include path.
*/
package lpac_pkg;
  `include "lpac_map.svh"

  typedef enum logic [1:0] {
    LPAC_DRV_RES = 2'h0,
    LPAC_DRV_BOOST = 2'h1,
    LPAC_DRV_CAP = 2'h2
  } lpac_drv_t;

  typedef enum logic [1:0] {
    LPAC_AR_A = 2'h0,
    LPAC_AR_B = 2'h1,
    LPAC_AR_BLINK = 2'h2
  } lpac_area_t;

  typedef enum logic [3:0] {
    LPAC_ST_IDLE = 4'h1,
    LPAC_ST_VREF = 4'h2,
    LPAC_ST_BOOST = 4'h4,
    LPAC_ST_SWAP = 4'h8
  } lpac_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } lpac_bus_t;

  typedef struct packed {
    logic seg_on;
    logic circuit_on;
    lpac_drv_t method;
    logic show_b;
  } lpac_drive_t;
endpackage

// File: lpac_ctrl.sv
/*
  Display drive power and area controller: turn-off forms, circuit on/off with
  boost wait, drive method swap, area select and blinking, segment nibble store.
  Assumes a same-clock register master, rtc tick and rtc_run from other clock
  logic (synchronised here), and a panel driver fed by the drive outputs.
*/
//
// Behaviour
// - Two turn-off forms: blank, blank plus halt
// - Halt form refused under resistor division
// - Halting circuit falls back to resistor division
// - Redisplay waits setup plus boost, or boost
// - Boost wait timed here or by software
// - Disable stops circuit, then resistor division
// - Circuit requests only for boost/cap; reject undefined
// - One request changes method, area or both
// - Only boost-to-cap and cap-to-boost swaps
// - Method swap: blank and apply together, then redisplay
// - Area: first, second, or blinking
// - Blinking refused while rtc not running
// - Contrast change only under boosting
// - Low nibble first, high nibble second pattern
// - Masked update rewrites zero-mask bits only
`timescale 1ns/1ns
module lpac_ctrl
  import lpac_pkg::*;
#(
  parameter int unsigned BOOST_CYC = `LPAC_BOOST_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic rtc_tick,
  input wire logic rtc_run,
  output logic [3:0] seg_pattern,
  output logic seg_enable,
  output logic circuit_on,
  output logic [1:0] drive_method
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic gen_ok(input lpac_drv_t m);
    gen_ok = (m == LPAC_DRV_BOOST) || (m == LPAC_DRV_CAP);
  endfunction
  function automatic logic hit(input logic [3:0] a, input logic [3:0] off, input logic s);
    hit = s && (a == off);
  endfunction
  localparam logic [31:0] VREF_CYC = 32'(`LPAC_VREF_CYC);
  localparam logic [31:0] BOOST_W = 32'(BOOST_CYC);

  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  logic [1:0] tick_sync_ff;
  logic [1:0] run_sync_ff;
  logic tick_old_ff;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_sync_ff <= 2'h0;
      run_sync_ff <= 2'h0;
      tick_old_ff <= 1'b0;
    end else begin
      tick_sync_ff <= {tick_sync_ff[0], rtc_tick};
      run_sync_ff <= {run_sync_ff[0], rtc_run};
      tick_old_ff <= tick_sync_ff[1];
    end
  end
  wire tick_rise = tick_sync_ff[1] && !tick_old_ff;
  wire rtc_ok = run_sync_ff[1];

  // ---------------------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------------------
  lpac_bus_t bus;
  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  wire [3:0] op = bus.wdata[`LPAC_CMD_OP_LSB +: 4];
  wire [3:0] arg = bus.wdata[`LPAC_CMD_ARG_LSB +: 4];
  wire [3:0] area_sel = bus.wdata[`LPAC_CMD_AREA_LSB +: 4];
  wire cmd_wr = hit(bus.addr, `LPAC_OFF_CMD, bus.wr);

  lpac_state_t st_ff, nxt_st;
  lpac_drive_t drv_ff, nxt_drv;
  lpac_drv_t saved_ff, nxt_saved;
  lpac_area_t area_ff, nxt_area;
  logic [2:0] cfg_ff, nxt_cfg;
  logic [31:0] cnt_ff, nxt_cnt;
  logic err_ff, nxt_err;
  logic rtc_err_ff, nxt_rtc_err;
  logic ready_ff, nxt_ready;
  logic redisp_ff, nxt_redisp;
  logic [7:0] seg_ff, nxt_seg;
  logic [3:0] contr_ff, nxt_contr;
  logic [15:0] rdata_ff, nxt_rdata;
  lpac_drv_t cfg_gen;
  lpac_drv_t tgt;
  logic swap_ok;
  logic area_ok;
  assign cfg_gen = lpac_drv_t'(cfg_ff[`LPAC_CFG_GEN_LSB +: 2]);
  always_comb begin
    nxt_st = st_ff;
    nxt_drv = drv_ff;
    nxt_saved = saved_ff;
    nxt_area = area_ff;
    nxt_cfg = cfg_ff;
    nxt_cnt = cnt_ff;
    nxt_err = err_ff;
    nxt_rtc_err = rtc_err_ff;
    nxt_ready = ready_ff;
    nxt_redisp = redisp_ff;
    nxt_seg = seg_ff;
    nxt_contr = contr_ff;
    tgt = LPAC_DRV_RES;
    swap_ok = 1'b0;
    area_ok = 1'b0;
    case (st_ff)
      LPAC_ST_IDLE: begin
        if (hit(bus.addr, `LPAC_OFF_CFG, bus.wr)) begin
          nxt_cfg = bus.wdata[2:0];
          nxt_drv.method = (bus.wdata[2:1] == 2'h3) ? LPAC_DRV_RES : lpac_drv_t'(bus.wdata[`LPAC_CFG_GEN_LSB +: 2]);
          nxt_saved = nxt_drv.method;
        end
        if (hit(bus.addr, `LPAC_OFF_SEG, bus.wr)) begin
          nxt_seg = (seg_ff & bus.wdata[15:8]) | (bus.wdata[7:0] & ~bus.wdata[15:8]);
        end
        if (hit(bus.addr, `LPAC_OFF_CONTR, bus.wr)) begin
          if (drv_ff.method == LPAC_DRV_BOOST) begin
            nxt_contr = bus.wdata[3:0];
          end else begin
            nxt_err = 1'b1;
          end
        end
        if (cmd_wr) begin
          nxt_err = 1'b0;
          nxt_rtc_err = 1'b0;
          case (op)
            `LPAC_OP_DISP_ON: begin
              if (drv_ff.circuit_on && !ready_ff) begin
                nxt_err = 1'b1;
              end else begin
                nxt_drv.seg_on = 1'b1;
              end
            end
            `LPAC_OP_OFF_BLANK: nxt_drv.seg_on = 1'b0;
            `LPAC_OP_OFF_HALT: begin
              if (!gen_ok(drv_ff.method)) begin
                nxt_err = 1'b1;
              end else begin
                nxt_drv.seg_on = 1'b0;
                nxt_drv.circuit_on = 1'b0;
                nxt_saved = drv_ff.method;
                nxt_drv.method = LPAC_DRV_RES;
                nxt_ready = 1'b0;
              end
            end
            `LPAC_OP_CIRC_EN, `LPAC_OP_CIRC_DIS: begin
              // only for boost or cap generator
              if (!gen_ok(cfg_gen)) begin
                nxt_err = 1'b1;
              end else if (op == `LPAC_OP_CIRC_EN) begin
                nxt_drv.method = saved_ff;
                nxt_drv.circuit_on = 1'b1;
                nxt_ready = 1'b0;
                nxt_cnt = 32'h0;
                if (cfg_ff[`LPAC_CFG_SELF_WAIT]) begin
                  // wait here, setup only for boost
                  nxt_st = (saved_ff == LPAC_DRV_BOOST) ? LPAC_ST_VREF : LPAC_ST_BOOST;
                end else begin
                  nxt_ready = 1'b1;
                end
              end else begin
                nxt_drv.circuit_on = 1'b0;
                nxt_drv.seg_on = 1'b0;
                nxt_st = LPAC_ST_SWAP;
              end
            end
            `LPAC_OP_CONTROL: begin
              if (arg[0]) begin
                swap_ok = (bus.wdata[15:12] == `LPAC_SEL_B2C && drv_ff.method == LPAC_DRV_BOOST) ||
                  (bus.wdata[15:12] == `LPAC_SEL_C2B && drv_ff.method == LPAC_DRV_CAP);
                tgt = (bus.wdata[15:12] == `LPAC_SEL_B2C) ? LPAC_DRV_CAP : LPAC_DRV_BOOST;
              end
              if (arg[1]) begin
                area_ok = (area_sel == `LPAC_AREA_A) || (area_sel == `LPAC_AREA_B) ||
                  (area_sel == `LPAC_AREA_BLINK);
              end
              if ((arg[0] && !swap_ok) || (arg[1] && !area_ok) || arg[3:2] != 2'h0 || arg[1:0] == 2'h0) begin
                nxt_err = 1'b1;
              end else if (arg[1] && area_sel == `LPAC_AREA_BLINK && !rtc_ok) begin
                nxt_rtc_err = 1'b1;
              end else begin
                if (arg[0]) begin
                  nxt_drv.method = tgt;
                  nxt_saved = tgt;
                  nxt_redisp = drv_ff.seg_on;
                  nxt_drv.seg_on = 1'b0;
                  nxt_st = LPAC_ST_SWAP;
                end
                if (arg[1]) begin
                  nxt_area = (area_sel == `LPAC_AREA_A) ? LPAC_AR_A :
                             (area_sel == `LPAC_AREA_B) ? LPAC_AR_B : LPAC_AR_BLINK;
                  nxt_drv.show_b = (area_sel == `LPAC_AREA_B);
                end
              end
            end
            default: nxt_err = 1'b1;
          endcase
        end
      end
      LPAC_ST_VREF: begin
        nxt_cnt = cnt_ff + 32'h1;
        if (nxt_cnt >= VREF_CYC) begin
          nxt_cnt = 32'h0;
          nxt_st = LPAC_ST_BOOST;
        end
      end
      LPAC_ST_BOOST: begin
        nxt_cnt = cnt_ff + 32'h1;
        if (nxt_cnt >= BOOST_W) begin
          nxt_ready = 1'b1;
          nxt_st = LPAC_ST_IDLE;
        end
      end
      LPAC_ST_SWAP: begin
        // Second step of disable or method swap
        if (!drv_ff.circuit_on && drv_ff.method != LPAC_DRV_RES && !redisp_ff) begin
          nxt_saved = drv_ff.method;
          nxt_drv.method = LPAC_DRV_RES;
          nxt_ready = 1'b0;
        end else if (redisp_ff) begin
          nxt_drv.seg_on = 1'b1;
        end
        nxt_redisp = 1'b0;
        nxt_st = LPAC_ST_IDLE;
      end
      default: nxt_st = LPAC_ST_IDLE;
    endcase
    if (area_ff == LPAC_AR_BLINK && tick_rise) begin
      nxt_drv.show_b = ~nxt_drv.show_b;
    end
  end

  always_comb begin
    nxt_rdata = 16'h0;
    if (bus.rd) begin
      case (bus.addr)
        `LPAC_OFF_CFG: nxt_rdata = {13'h0, cfg_ff};
        `LPAC_OFF_STATUS: nxt_rdata = {4'h0, st_ff, area_ff, drv_ff.method, rtc_err_ff, err_ff, ready_ff,
                                       drv_ff.circuit_on};
        `LPAC_OFF_SEG: nxt_rdata = {8'h0, seg_ff};
        `LPAC_OFF_CONTR: nxt_rdata = {12'h0, contr_ff};
        default: nxt_rdata = 16'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= LPAC_ST_IDLE;
      drv_ff <= '{seg_on: 1'b0, circuit_on: 1'b0, method: LPAC_DRV_RES, show_b: 1'b0};
      saved_ff <= LPAC_DRV_RES;
      area_ff <= LPAC_AR_A;
      cfg_ff <= `LPAC_CFG_RESET;
      cnt_ff <= 32'h0;
      err_ff <= 1'b0;
      rtc_err_ff <= 1'b0;
      ready_ff <= 1'b0;
      redisp_ff <= 1'b0;
      seg_ff <= 8'h0;
      contr_ff <= 4'h0;
      rdata_ff <= 16'h0;
    end else begin
      st_ff <= nxt_st;
      drv_ff <= nxt_drv;
      saved_ff <= nxt_saved;
      area_ff <= nxt_area;
      cfg_ff <= nxt_cfg;
      cnt_ff <= nxt_cnt;
      err_ff <= nxt_err;
      rtc_err_ff <= nxt_rtc_err;
      ready_ff <= nxt_ready;
      redisp_ff <= nxt_redisp;
      seg_ff <= nxt_seg;
      contr_ff <= nxt_contr;
      rdata_ff <= nxt_rdata;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  logic [3:0] pat_ff;
  logic en_ff;
  logic circ_ff;
  logic [1:0] meth_ff;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pat_ff <= 4'h0;
      en_ff <= 1'b0;
      circ_ff <= 1'b0;
      meth_ff <= 2'h0;
    end else begin
      pat_ff <= drv_ff.show_b ? seg_ff[7:4] : seg_ff[3:0];
      en_ff <= drv_ff.seg_on;
      circ_ff <= drv_ff.circuit_on;
      meth_ff <= drv_ff.method;
    end
  end
  assign seg_pattern = pat_ff;
  assign seg_enable = en_ff;
  assign circuit_on = circ_ff;
  assign drive_method = meth_ff;
  assign reg_rdata = rdata_ff;
endmodule

// File: lpac_props.sv
/*
  Port-level checker for the drive power and area controller.
  Assumes binding onto lpac_ctrl and the one clk_sys domain.
*/
`timescale 1ns/1ns
module lpac_props
  import lpac_pkg::*;
#(
  parameter int unsigned BOOST_CYC = 20
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic rtc_tick,
  input wire logic rtc_run,
  input wire logic [3:0] seg_pattern,
  input wire logic seg_enable,
  input wire logic circuit_on,
  input wire logic [1:0] drive_method
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic cmd_wr;
  logic [3:0] op;
  assign cmd_wr = reg_wr && reg_addr == 4'h0;
  assign op = reg_wdata[3:0];

  property p_drv_legal;
    drive_method != 2'h3;
  endproperty
  a_drv_legal: assert property (p_drv_legal) else $error("drive method code out of range");
  property p_halt_refused;
    cmd_wr && op == 4'h3 && drive_method == 2'h0 && !circuit_on |->
      ##2 (seg_enable == $past(seg_enable, 2) && !circuit_on);
  endproperty
  a_halt_refused: assert property (p_halt_refused) else $error("halt form acted under divider");
  property p_halt_form;
    cmd_wr && op == 4'h3 && circuit_on |-> ##[2:3] !seg_enable;
  endproperty
  a_halt_form: assert property (p_halt_form) else $error("halt form left display on");
  property p_fallback;
    cmd_wr && (op == 4'h3 || op == 4'h5) && circuit_on |-> ##[2:5] (!circuit_on && drive_method == 2'h0);
  endproperty
  a_fallback: assert property (p_fallback) else $error("no fall back to divider");
  property p_disable_order;
    cmd_wr && op == 4'h5 && circuit_on |-> ##[1:4] (!circuit_on && drive_method != 2'h0);
  endproperty
  a_disable_order: assert property (p_disable_order) else $error("method left before circuit stop");
  property p_circ_method;
    circuit_on && $past(circuit_on) |-> drive_method != 2'h0;
  endproperty
  a_circ_method: assert property (p_circ_method) else $error("circuit running under divider");
  property p_swap_blank;
    drive_method != 2'h0 && $past(drive_method) != 2'h0 && $changed(drive_method) |-> !seg_enable;
  endproperty
  a_swap_blank: assert property (p_swap_blank) else $error("method swapped while shown");
  property p_blank_only;
    cmd_wr && op == 4'h2 |-> ##2 (!seg_enable && circuit_on == $past(circuit_on, 2));
  endproperty
  a_blank_only: assert property (p_blank_only) else $error("blank form touched circuit");
  property p_boost_wait;
    $rose(circuit_on) |-> !seg_enable [*8];
  endproperty
  a_boost_wait: assert property (p_boost_wait) else $error("display on before boost wait");
endmodule

bind lpac_ctrl lpac_props #(.BOOST_CYC(BOOST_CYC)) u_props (.clk_sys(clk_sys), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .rtc_tick(rtc_tick), .rtc_run(rtc_run), .seg_pattern(seg_pattern), .seg_enable(seg_enable),
  .circuit_on(circuit_on), .drive_method(drive_method));

// File: lpac_panel.sv
/*
  Glass panel model: what the commons show.
  Assumes the controller's seg outputs drive it directly.
*/
`timescale 1ns/1ns
module lpac_panel (
  input wire logic [3:0] seg_pattern,
  input wire logic seg_enable,
  output logic [3:0] shown
);
  // Blanked glass lights nothing
  assign shown = seg_enable ? seg_pattern : 4'h0;
endmodule

// File: tb_top.sv
/*
  Self-checking bench for lpac_ctrl with the panel model.
  Assumes BOOST_CYC of 20 and a same-clock register master.
*/
`timescale 1ns/1ns
module tb_top;
  import lpac_pkg::*;
  logic clk_sys, rst_n, reg_wr, reg_rd, rtc_tick, rtc_run, seg_enable, circuit_on;
  logic [3:0] reg_addr, seg_pattern, shown;
  logic [15:0] reg_wdata, reg_rdata, rd_val;
  logic [1:0] drive_method;
  int mismatches = 0, tests_run = 0, cyc = 0, k;
  lpac_ctrl #(.BOOST_CYC(20)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rtc_tick(rtc_tick),
    .rtc_run(rtc_run), .seg_pattern(seg_pattern), .seg_enable(seg_enable), .circuit_on(circuit_on),
    .drive_method(drive_method));
  lpac_panel u_panel (.seg_pattern(seg_pattern), .seg_enable(seg_enable), .shown(shown));

  // ---------------------------------------------------------------------------
  // Clock, timeout, report
  // ---------------------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic close_out();
    $display("mismatches=%0d tests_run=%0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end

  // ---------------------------------------------------------------------------
  // Bus tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // Output view: enable, circuit, method, panel nibble
  task automatic out(input logic [15:0] exp);
    settle(12);
    chk({8'h00, seg_enable, circuit_on, drive_method, shown}, exp);
  endtask
  task automatic st_bit(input int b, input logic v);
    rd(4'h2, rd_val);
    chk({15'h0000, rd_val[b]}, {15'h0000, v});
  endtask
  // Poll ready; each poll spans two cycles
  task automatic wait_ready();
    for (k = 0; k < 400; k++) begin
      rd(4'h2, rd_val);
      if (rd_val[1] === 1'b1) break;
    end
  endtask
  task automatic tick();
    @(posedge clk_sys);
    rtc_tick <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rtc_tick <= 1'b0;
  endtask

  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rtc_tick = 1'b0;
    rtc_run = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(4'h1, rd_val);
    chk(rd_val, 16'h0001);
    out(16'h0000);
    wr(4'h0, 16'h0003);
    st_bit(2, 1'b1);
    for (int op = 4; op < 6; op++) begin
      wr(4'h0, 16'(op));
      st_bit(2, 1'b1);
    end
    wr(4'h3, 16'h00a5);
    rd(4'h3, rd_val);
    chk(rd_val, 16'h00a5);
    wr(4'h0, 16'h0001);
    out(16'h0085);
    wr(4'h0, 16'h0226);
    out(16'h008a);
    wr(4'h3, 16'hf00c);
    rd(4'h3, rd_val);
    chk(rd_val, 16'h00ac);
    wr(4'h0, 16'h0126);
    out(16'h008c);
    // Blink asked before the tick source runs
    wr(4'h0, 16'h0326);
    st_bit(3, 1'b1);
    out(16'h008c);
    // Run level needs two sync stages before the request
    @(posedge clk_sys);
    rtc_run <= 1'b1;
    settle(3);
    wr(4'h0, 16'h0326);
    st_bit(3, 1'b0);
    out(16'h008c);
    tick();
    out(16'h008a);
    tick();
    out(16'h008c);
    wr(4'h0, 16'h0126);
    wr(4'h0, 16'h0002);
    out(16'h0000);
    wr(4'h1, 16'h0003);
    wr(4'h0, 16'h0004);
    wait_ready();
    chk(16'(k >= 255 && k < 300), 16'h0001);
    out(16'h0050);
    wr(4'h0, 16'h0001);
    out(16'h00dc);
    wr(4'h4, 16'h0007);
    rd(4'h4, rd_val);
    chk(rd_val, 16'h0007);
    st_bit(2, 1'b0);
    wr(4'h0, 16'h0002);
    out(16'h0050);
    wr(4'h0, 16'h0001);
    out(16'h00dc);
    wr(4'h0, 16'h1016);
    out(16'h00ec);
    wr(4'h0, 16'h1016);
    st_bit(2, 1'b1);
    wr(4'h4, 16'h0003);
    st_bit(2, 1'b1);
    rd(4'h4, rd_val);
    chk(rd_val, 16'h0007);
    wr(4'h0, 16'h0003);
    out(16'h0000);
    // Circuit back first, display after
    wr(4'h0, 16'h0004);
    wait_ready();
    chk(16'(k >= 5 && k < 20), 16'h0001);
    out(16'h0060);
    wr(4'h0, 16'h0001);
    out(16'h00ec);
    // Method and area changed by one request
    wr(4'h0, 16'h2236);
    out(16'h00da);
    wr(4'h0, 16'h0005);
    settle(12);
    chk({14'h0000, circuit_on, drive_method != 2'h0}, 16'h0000);
    close_out();
  end
endmodule
